// File: rtl/mode_read_path.sv
// Mode register read path with segment/bank refresh gating and calibration readout
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Segment masks work alone or together with bank masks for self refresh.
// - Each segment mask bit applies to that segment in all banks.
// - In unmasked banks, masked segments are not self-refreshed.
// - Mask bit 1 blocks refresh; a cell needs bank and segment unmasked.
// - A masked bank gets no refresh at all and no retention.
// - Read decoded on CS_n low with CA3..CA0 equal to 1000.
// - Address is fall CA1:CA0 above rise CA9:CA4.
// - Register value on DQ7..0 in first beat after read latency.
// - Later beats and upper DQ lines carry defined filler.
// - All strobe pairs toggle for the whole read burst.
// - Every mode register read burst is four beats.
// - Reserved or write-only reads still give a full strobed burst.
// - Temperature status refreshed at least every sensor interval.
// - Status no older than one interval on low-power exit.
// - Temperature state reported in bits 2:0 of its register.
// - Addresses 32 and 40 return patterns A and B on each lane bit 0.
// - Pattern A is 1,0,1,0 and pattern B is 0,0,1,1 per beat.
// - Other bits of each byte copy bit 0 during calibration reads.
// - Reads accepted idle or active; prior bank state kept afterward.
module mode_read_path #(
  parameter int unsigned TSI_LIMIT = mrr_pkg::TSI_CYCLES
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic cs_n_i,
  input wire logic [mrr_pkg::CA_WIDTH-1:0] ca_rise_i,
  input wire logic [mrr_pkg::CA_WIDTH-1:0] ca_fall_i,
  input wire logic banks_active_i,
  input wire logic [mrr_pkg::BANKS-1:0] bank_mask_i,
  input wire logic [mrr_pkg::SEGMENTS-1:0] seg_mask_i,
  input wire logic [mrr_pkg::TEMP_WIDTH-1:0] sensor_code_i,
  input wire logic low_power_exit_i,
  output var logic [mrr_pkg::DQ_WIDTH-1:0] dq_o,
  output var logic dq_oe_b_o,
  output var logic [mrr_pkg::BYTE_LANES-1:0] dqs_t_o,
  output var logic [mrr_pkg::BYTE_LANES-1:0] dqs_c_o,
  output var logic dqs_oe_b_o,
  output var logic mrr_busy_o,
  output var logic banks_active_o,
  output var logic [mrr_pkg::BANKS*mrr_pkg::SEGMENTS-1:0] refresh_en_o,
  output var logic [mrr_pkg::TEMP_WIDTH-1:0] temp_status_o,
  output var logic temp_update_o
);
  import mrr_pkg::*;

  mrr_state_t state;
  mrr_state_t next_state;
  logic [3:0] lat_count;
  logic [3:0] next_lat_count;
  logic [1:0] beat;
  logic [1:0] next_beat;
  logic [MA_WIDTH-1:0] addr;
  logic mrr_cmd;
  logic saved_active;

  temp_if tif();

  temp_sensor_sampler #(
    .TSI_LIMIT(TSI_LIMIT)
  ) sampler (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .sensor_code_i(sensor_code_i),
    .low_power_exit_i(low_power_exit_i),
    .tif(tif)
  );

  // Command decode; commands during a read are ignored, the controller must not send them
  assign mrr_cmd = !cs_n_i && (ca_rise_i[3:0] == MRR_OPCODE);

  // Word driven on one beat of the burst
  function automatic logic [DQ_WIDTH-1:0] beat_data(input logic [MA_WIDTH-1:0] ma, input logic [1:0] b);
    logic [DQ_WIDTH-1:0] word;
    word = '0;
    if (ma == MA_CAL_A)
      word = {DQ_WIDTH{PATTERN_A[b]}};
    else if (ma == MA_CAL_B)
      word = {DQ_WIDTH{PATTERN_B[b]}};
    else if (b == FIRST_BEAT)
    begin
      // Upper lanes and reserved addresses read as zero filler
      if (ma == MA_TEMP)
        word[7:0] = {5'h00, tif.status};
      else if (ma == MA_BANK_MASK)
        word[7:0] = bank_mask_i;
      else if (ma == MA_SEG_MASK)
        word[7:0] = seg_mask_i;
    end
    return word;
  endfunction

  always_comb
  begin
    next_state = state;
    next_lat_count = lat_count;
    next_beat = beat;
    case (state)
      ST_IDLE:
      begin
        if (mrr_cmd)
        begin
          next_state = ST_LATENCY;
          next_lat_count = READ_LATENCY - 4'h1;
        end
      end
      ST_LATENCY:
      begin
        if (lat_count == 4'h0)
        begin
          next_state = ST_BURST;
          next_beat = FIRST_BEAT;
        end
        else
          next_lat_count = lat_count - 4'h1;
      end
      ST_BURST:
      begin
        // Fixed four beats whatever the normal burst length
        if (beat == LAST_BEAT)
          next_state = ST_IDLE;
        else
          next_beat = beat + 2'h1;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      state <= ST_IDLE;
      lat_count <= 4'h0;
      beat <= FIRST_BEAT;
    end
    else
    begin
      state <= next_state;
      lat_count <= next_lat_count;
      beat <= next_beat;
    end
  end

  // Address capture
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      addr <= 8'h00;
    else if (state == ST_IDLE && mrr_cmd)
      addr <= {ca_fall_i[1:0], ca_rise_i[9:4]};
  end

  // Bank state is held through the read and handed back unchanged
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      saved_active <= 1'b0;
    else if (state == ST_IDLE)
      saved_active <= banks_active_i;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      mrr_busy_o <= 1'b0;
      banks_active_o <= 1'b0;
    end
    else
    begin
      mrr_busy_o <= (next_state != ST_IDLE);
      // The command edge itself passes the live state so the held value never steps mid-read
      banks_active_o <= (next_state == ST_IDLE || state == ST_IDLE) ? banks_active_i : saved_active;
    end
  end

  // Data and strobes loaded from the next beat so outputs come straight from flops
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      dq_o <= 32'h0000_0000;
      dq_oe_b_o <= 1'b1;
      dqs_oe_b_o <= 1'b1;
      dqs_t_o <= '0;
      dqs_c_o <= '1;
    end
    else if (next_state == ST_BURST)
    begin
      dq_o <= beat_data(addr, next_beat);
      dq_oe_b_o <= 1'b0;
      dqs_oe_b_o <= 1'b0;
      dqs_t_o <= {BYTE_LANES{~next_beat[0]}};
      dqs_c_o <= {BYTE_LANES{next_beat[0]}};
    end
    else
    begin
      dq_o <= 32'h0000_0000;
      dq_oe_b_o <= 1'b1;
      dqs_oe_b_o <= 1'b1;
      dqs_t_o <= '0;
      dqs_c_o <= '1;
    end
  end

  // Refresh gate per bank and segment; an all-zero mask disables that scheme
  genvar gb, gs;
  generate
    for (gb = 0; gb < BANKS; gb++)
    begin : g_bank
      for (gs = 0; gs < SEGMENTS; gs++)
      begin : g_seg
        always_ff @(posedge clock_i)
        begin
          if (!rst_b_i)
            refresh_en_o[gb*SEGMENTS+gs] <= 1'b1;
          else
            refresh_en_o[gb*SEGMENTS+gs] <= !bank_mask_i[gb] && !seg_mask_i[gs];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      temp_status_o <= TEMP_RESET_CODE;
      temp_update_o <= 1'b0;
    end
    else
    begin
      temp_status_o <= tif.status;
      temp_update_o <= tif.updated;
    end
  end

  mrr_decode_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!mrr_busy_o && !cs_n_i && ca_rise_i[3:0] == MRR_OPCODE) |=> mrr_busy_o)
    else $error("mode register read not decoded");

  read_latency_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (state == ST_IDLE && mrr_cmd) |-> ##1 dq_oe_b_o ##1 dq_oe_b_o ##1 dq_oe_b_o ##1 !dq_oe_b_o)
    else $error("first beat not at read latency");

  burst_four_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(dq_oe_b_o) |-> !dq_oe_b_o[*4] ##1 dq_oe_b_o)
    else $error("read burst is not four beats");

  strobe_toggle_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!dqs_oe_b_o && $past(!dqs_oe_b_o)) |-> (dqs_t_o == ~$past(dqs_t_o)) && (dqs_c_o == ~dqs_t_o))
    else $error("strobes not toggling during burst");

  strobe_with_data_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    dq_oe_b_o == dqs_oe_b_o)
    else $error("strobes not driven with data");

  seg_readback_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ($fell(dq_oe_b_o) && addr == MA_SEG_MASK) |-> dq_o == {24'h00_0000, $past(seg_mask_i)})
    else $error("segment mask not on first beat");

  cal_pattern_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ($fell(dq_oe_b_o) && addr == MA_CAL_A) |->
      dq_o == 32'hFFFF_FFFF ##1 dq_o == 32'h0000_0000 ##1 dq_o == 32'hFFFF_FFFF ##1 dq_o == 32'h0000_0000)
    else $error("calibration pattern A wrong");

  cal_pattern_b_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ($fell(dq_oe_b_o) && addr == MA_CAL_B) |->
      dq_o == 32'h0000_0000 ##1 dq_o == 32'h0000_0000 ##1 dq_o == 32'hFFFF_FFFF ##1 dq_o == 32'hFFFF_FFFF)
    else $error("calibration pattern B wrong");

  refresh_gate_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##1 refresh_en_o[9] == !($past(bank_mask_i[1]) || $past(seg_mask_i[1])))
    else $error("refresh gate ignores a mask");

  bank_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (mrr_busy_o && $past(mrr_busy_o)) |-> $stable(banks_active_o))
    else $error("bank state changed during read");

endmodule
`default_nettype wire

// File: inc/mrr_pkg.sv
// Shared constants and types for the mode-register read path
package mrr_pkg;

  localparam int unsigned DQ_WIDTH = 32;
  localparam int unsigned BYTE_LANES = 4;
  localparam int unsigned CA_WIDTH = 10;
  localparam int unsigned BANKS = 8;
  localparam int unsigned SEGMENTS = 8;
  localparam int unsigned TEMP_WIDTH = 3;
  localparam int unsigned MA_WIDTH = 8;

  // Command code on CA3..CA0 at the rising edge
  localparam logic [3:0] MRR_OPCODE = 4'h8;

  // Mode register addresses
  localparam logic [7:0] MA_TEMP = 8'h04;
  localparam logic [7:0] MA_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_SEG_MASK = 8'h11;
  localparam logic [7:0] MA_CAL_A = 8'h20;
  localparam logic [7:0] MA_CAL_B = 8'h28;

  // Calibration patterns, bit n is beat n
  localparam logic [3:0] PATTERN_A = 4'h5;
  localparam logic [3:0] PATTERN_B = 4'hC;

  // Burst and latency
  localparam logic [1:0] FIRST_BEAT = 2'h0;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [3:0] READ_LATENCY = 4'h3;

  // Reset values
  localparam logic [2:0] TEMP_RESET_CODE = 3'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Temperature sensor interval: longest time, rounded down
  localparam int unsigned CLOCK_PERIOD_NS = 100;
  localparam int unsigned TSI_MS = 32;
  localparam int unsigned TSI_CYCLES = (TSI_MS * 1000000) / CLOCK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LATENCY = 2'b01,
    ST_BURST = 2'b10
  } mrr_state_t;

endpackage

// File: inc/temp_if.sv
// Temperature status carried from the sensor sampler to the read path
`timescale 1ns/1ps
`default_nettype none
interface temp_if;
  logic [mrr_pkg::TEMP_WIDTH-1:0] status;
  logic updated;
  modport sensor(output status, output updated);
  modport reader(input status, input updated);
endinterface
`default_nettype wire

// File: rtl/temp_sensor_sampler.sv
// Periodic sampler that refreshes the temperature status field
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_sampler #(
  parameter int unsigned TSI_LIMIT = mrr_pkg::TSI_CYCLES
)
(
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [mrr_pkg::TEMP_WIDTH-1:0] sensor_code_i,
  input wire logic low_power_exit_i,
  temp_if.sensor tif
);
  import mrr_pkg::*;

  localparam int unsigned CW = $clog2(TSI_LIMIT + 1);
  localparam logic [CW-1:0] RELOAD = CW'(TSI_LIMIT - 1);

  logic [CW-1:0] interval_count;
  logic [CW-1:0] since_update;
  logic fire;

  // Exit from a low-power state forces a fresh sample
  assign fire = (interval_count == '0) || low_power_exit_i;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      interval_count <= RELOAD;
    else if (fire)
      interval_count <= RELOAD;
    else
      interval_count <= interval_count - 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      tif.status <= TEMP_RESET_CODE;
      tif.updated <= 1'b0;
    end
    else
    begin
      tif.updated <= fire;
      if (fire)
        tif.status <= sensor_code_i;
    end
  end

  // Helper: cycles since the last published update
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      since_update <= '0;
    else if (tif.updated)
      since_update <= '0;
    else
      since_update <= since_update + 1'b1;
  end

  tsi_interval_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) since_update <= CW'(TSI_LIMIT))
    else $error("temperature status older than the sensor interval");

  exit_refresh_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    low_power_exit_i |=> tif.updated && tif.status == $past(sensor_code_i))
    else $error("status not refreshed on low-power exit");

endmodule
`default_nettype wire

// File: tb/mrr_host_model.sv
// Host controller model that issues mode register reads on the command bus
`timescale 1ns/1ps
`default_nettype none
module mrr_host_model (
  input wire logic clock_i,
  output var logic cs_n_o,
  output var logic [mrr_pkg::CA_WIDTH-1:0] ca_rise_o,
  output var logic [mrr_pkg::CA_WIDTH-1:0] ca_fall_o
);
  import mrr_pkg::*;
  initial
  begin
    cs_n_o = 1'b1;
    ca_rise_o = 10'h155;
    ca_fall_o = 10'h2aa;
  end
  // Returns one cycle after the command; the caller only calls again after the burst
  task automatic mrr(input logic [7:0] ma);
    @(posedge clock_i);
    #1;
    cs_n_o = 1'b0;
    ca_rise_o = {ma[5:0], MRR_OPCODE};
    ca_fall_o = {8'h00, ma[7:6]};
    @(posedge clock_i);
    #1;
    // Deselected: inverted lines so stale values never look valid
    cs_n_o = 1'b1;
    ca_rise_o = ~ca_rise_o;
    ca_fall_o = ~ca_fall_o;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_mode_read_path.sv
// Self-checking testbench for the mode register read path
`timescale 1ns/1ps
`default_nettype none
module tb_mode_read_path;
  import mrr_pkg::*;
  localparam int unsigned TSI = 20;
  logic clock_i, rst_b_i, cs_n, act_i, lpe_i, dq_oe_b, dqs_oe_b, busy, act_o, tupd;
  logic [9:0] ca_r, ca_f;
  logic [7:0] bmask, smask;
  logic [2:0] sensor, tstat;
  logic [31:0] dq;
  logic [3:0] dqs_t, dqs_c;
  logic [63:0] ref_en;
  int err_count = 0;
  int n_checks = 0;
  mrr_host_model host (.clock_i(clock_i), .cs_n_o(cs_n), .ca_rise_o(ca_r), .ca_fall_o(ca_f));
  mode_read_path #(.TSI_LIMIT(TSI)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .cs_n_i(cs_n),
    .ca_rise_i(ca_r), .ca_fall_i(ca_f), .banks_active_i(act_i), .bank_mask_i(bmask),
    .seg_mask_i(smask), .sensor_code_i(sensor), .low_power_exit_i(lpe_i), .dq_o(dq),
    .dq_oe_b_o(dq_oe_b), .dqs_t_o(dqs_t), .dqs_c_o(dqs_c), .dqs_oe_b_o(dqs_oe_b),
    .mrr_busy_o(busy), .banks_active_o(act_o), .refresh_en_o(ref_en),
    .temp_status_o(tstat), .temp_update_o(tupd));
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Expected beat k of a read, worked out independently of the design
  function automatic logic [31:0] beat(input logic [7:0] ma, input int k);
    if (ma == 8'h20)
      return (k % 2 == 0) ? 32'hffff_ffff : 32'h0000_0000;
    if (ma == 8'h28)
      return (k >= 2) ? 32'hffff_ffff : 32'h0000_0000;
    if (k != 0)
      return 32'h0000_0000;
    case (ma)
      8'h04: return {29'h0, sensor};
      8'h10: return {24'h0, bmask};
      8'h11: return {24'h0, smask};
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic t_reset();
    chk("oe", {dq_oe_b, dqs_oe_b, busy}, 3'h6);
    chk("dqs", {dqs_t, dqs_c}, 8'h0f);
    chk("refresh_en", ref_en, 64'hffff_ffff_ffff_ffff);
    chk("temp", tstat, 3'h0);
    $display("reset test done");
  endtask
  task automatic t_refresh();
    logic [15:0] tbl [5] = '{16'h00_81, 16'hff_00, 16'h02_00, 16'h00_02, 16'h82_84};
    logic [63:0] exp;
    foreach (tbl[i])
    begin
      @(posedge clock_i);
      #1;
      {bmask, smask} = tbl[i];
      @(posedge clock_i);
      @(negedge clock_i);
      for (int b = 0; b < 8; b++)
        for (int s = 0; s < 8; s++)
          exp[b*8+s] = !(bmask[b] | smask[s]);
      chk("refresh_en", ref_en, exp);
    end
    $display("refresh mask test done");
  endtask
  task automatic t_temp();
    int n;
    @(posedge clock_i);
    #1;
    sensor = 3'h3;
    lpe_i = 1'b1;
    @(posedge clock_i);
    #1;
    lpe_i = 1'b0;
    sensor = 3'h5;
    // Status and pulse leave the block one edge after the internal sample
    @(posedge clock_i);
    @(negedge clock_i);
    chk("temp after exit", {tstat, tupd}, 4'h7);
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (tupd !== 1'b1 && n < 3 * TSI);
    chk("update interval ok", n <= TSI + 1, 1'b1);
    chk("temp periodic", tstat, 3'h5);
    $display("temperature test done");
  endtask
  task automatic rd(input logic [7:0] ma, input logic act);
    @(posedge clock_i);
    #1;
    act_i = act;
    host.mrr(ma);
    act_i = 1'b0;
    repeat (3) @(posedge clock_i);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clock_i);
      chk("dq", dq, beat(ma, k));
      chk("dqs", {dqs_t, dqs_c}, (k % 2 == 0) ? 8'hf0 : 8'h0f);
      chk("oe during burst", {dq_oe_b, dqs_oe_b, busy}, 3'h1);
      chk("bank state", act_o, act);
      if (k < 3)
        @(posedge clock_i);
    end
    // No other command until the burst is over; no writes or terminated bursts are issued
    @(posedge clock_i);
    @(negedge clock_i);
    chk("oe after burst", {dq_oe_b, dqs_oe_b, busy}, 3'h6);
  endtask
  task automatic t_reads();
    // Calibration reads keep all banks idle
    rd(8'h04, 1'b0);
    rd(8'h10, 1'b1);
    rd(8'h11, 1'b0);
    rd(8'h05, 1'b1);
    rd(8'h51, 1'b0);
    rd(8'h20, 1'b0);
    rd(8'h28, 1'b0);
    $display("mode register read test done");
  endtask
  initial
  begin
    rst_b_i = 1'b0;
    act_i = 1'b0;
    lpe_i = 1'b0;
    bmask = 8'h00;
    smask = 8'h00;
    sensor = 3'h0;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    t_reset();
    @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    t_refresh();
    t_temp();
    t_reads();
    report_and_stop();
  end
  // Whole run needs about 107 cycles; allow nearly thirty times that
  initial
  begin
    #(3000 * 100);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
